// ===== shared/ttc_pkg.sv
package ttc_pkg;

  // register pointers
  localparam logic [7:0] ADDR_STATUS    = 8'h08;
  localparam logic [7:0] ADDR_RUN_RANGE = 8'h09;
  localparam logic [7:0] ADDR_CHAN_EN   = 8'h0A;
  localparam logic [7:0] ADDR_RATE      = 8'h0B;
  localparam logic [7:0] ADDR_ONE_SHOT  = 8'h0F;

  // field positions
  localparam int BIT_BUSY       = 7;
  localparam int BIT_SHUTDOWN   = 6;
  localparam int BIT_RANGE      = 2;
  localparam int BIT_RES_CORR   = 2;
  localparam int BIT_LOCAL_EN   = 3;
  localparam int BIT_REMOTE1_EN = 4;
  localparam int BIT_REMOTE2_EN = 5;
  localparam int RATE_LSB       = 0;
  localparam int RATE_W         = 3;

  // values after reset and writable-bit masks
  localparam logic [7:0] RST_STATUS          = 8'h00;
  localparam logic [7:0] RST_RUN_RANGE       = 8'h00;
  localparam logic [7:0] RST_CHAN_EN_SINGLE  = 8'h1C;
  localparam logic [7:0] RST_CHAN_EN_DUAL    = 8'h3C;
  localparam logic [7:0] RST_RATE            = 8'h07;
  localparam logic [7:0] MASK_RUN_RANGE      = 8'h44;
  localparam logic [7:0] MASK_CHAN_EN_SINGLE = 8'h1C;
  localparam logic [7:0] MASK_CHAN_EN_DUAL   = 8'h3C;
  localparam logic [7:0] MASK_RATE           = 8'h07;
  localparam logic [2:0] RATE_MAX            = 3'h7;

  // channel codes in sequence order
  localparam logic [1:0] CH_LOCAL   = 2'h0;
  localparam logic [1:0] CH_REMOTE1 = 2'h1;
  localparam logic [1:0] CH_REMOTE2 = 2'h2;

  // times in ns and derived cycle counts at 50 MHz
  localparam int unsigned CLK_PERIOD_NS     = 20;
  localparam int unsigned T_FIRST_SINGLE_NS = 100_000;
  localparam int unsigned T_FIRST_DUAL_NS   = 1_000_000;
  localparam int unsigned T_CONV_NS         = 31_250_000;
  localparam int unsigned T_SEQ_FAST_NS     = 125_000_000;
  localparam int unsigned FIRST_SINGLE_CYC  = T_FIRST_SINGLE_NS / CLK_PERIOD_NS;
  localparam int unsigned FIRST_DUAL_CYC    = T_FIRST_DUAL_NS / CLK_PERIOD_NS;
  localparam int unsigned CONV_CYC          = T_CONV_NS / CLK_PERIOD_NS;
  localparam int unsigned SEQ_FAST_CYC      = T_SEQ_FAST_NS / CLK_PERIOD_NS;

  // sequencer states
  typedef enum logic [1:0] {
    ST_POWERUP,
    ST_CONVERT,
    ST_IDLE,
    ST_SHUTDOWN
  } ttc_state_t;

endpackage

// ===== src/ttc_cfg_reg.sv
`timescale 1ns/1ps
module ttc_cfg_reg #(
  parameter logic [7:0] ADDR        = 8'h00,
  parameter logic [7:0] RESET_VALUE = 8'h00,
  parameter logic [7:0] WRITE_MASK  = 8'hFF
) (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       srst_in,
  // register port
  input  wire logic       wr_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  output logic [7:0]      value_out
);

  logic [7:0] value_reg;

  // only writable bits are stored, reserved bits stay zero
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      value_reg <= RESET_VALUE;
    end else if (wr_in && (addr_in == ADDR)) begin
      value_reg <= wdata_in & WRITE_MASK;
    end
  end

  assign value_out = value_reg;

endmodule

// ===== src/ttc_conversion_ctrl.sv
// Behaviour
// - status at 08h is read only
// - status bit 7 shows conversion active
// - single variant starts converting within 100us
// - dual variant starts converting after 1ms
// - run/range register at 09h read/write
// - run bit clear means continuous conversions
// - shutdown waits for running sequence end
// - clearing shutdown resumes continuous conversions
// - one-shot write in shutdown converts once
// - bit 2 selects standard or extended range
// - channel enable register at 0Ah read/write
// - bit 2 enables correction, doubles remote time
// - bit 3 enables local channel
// - bit 4 enables remote channel one
// - bit 5 enables remote two, dual only
// - enable register resets 1Ch or 3Ch
// - order local, remote1, remote2, shutdown, idle
// - disabled channels skipped in sequence
// - rate register sets the period from one sequence start to the next
// - one-shot in idle starts sequence immediately
// - rate codes 0..7 double rate, reset 07h
// - one-shot ignored while converting, not stored
// - each finished measurement updates its result
`timescale 1ns/1ps
module ttc_conversion_ctrl #(
  parameter bit          DUAL_REMOTE  = 1'b0,
  parameter int unsigned FIRST_CYC    = DUAL_REMOTE ? ttc_pkg::FIRST_DUAL_CYC
                                                    : ttc_pkg::FIRST_SINGLE_CYC,
  parameter int unsigned CONV_CYC     = ttc_pkg::CONV_CYC,
  parameter int unsigned SEQ_FAST_CYC = ttc_pkg::SEQ_FAST_CYC
) (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       srst_in,
  // register port
  input  wire logic [7:0] reg_addr_in,
  input  wire logic       reg_wr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_rd_in,
  output logic [7:0]      reg_rdata_out,
  // converter control
  output logic            conv_active_out,
  output logic [1:0]      conv_channel_out,
  output logic            series_res_correct_en_out,
  output logic            range_extended_out,
  // result update strobe
  output logic            result_update_out,
  output logic [1:0]      result_channel_out
);

  localparam logic [7:0] CHAN_RST  = DUAL_REMOTE ? ttc_pkg::RST_CHAN_EN_DUAL
                                                 : ttc_pkg::RST_CHAN_EN_SINGLE;
  localparam logic [7:0] CHAN_MASK = DUAL_REMOTE ? ttc_pkg::MASK_CHAN_EN_DUAL
                                                 : ttc_pkg::MASK_CHAN_EN_SINGLE;

  ttc_pkg::ttc_state_t state_reg;
  ttc_pkg::ttc_state_t state_next;
  logic [7:0]  run_range_cfg;
  logic [7:0]  channel_enable_cfg;
  logic [7:0]  sequence_rate;
  logic [1:0]  ch_reg;
  logic [1:0]  ch_next;
  logic        oneshot_reg;
  logic        oneshot_next;
  logic        busy_reg;
  logic        upd_reg;
  logic        upd_next;
  logic [1:0]  upd_ch_reg;
  logic        conv_load;
  logic        period_load;
  logic        start_seq;
  logic        conv_expired;
  logic        period_expired;
  logic [31:0] conv_value;
  logic [31:0] period_value;
  logic [2:0]  chan_en;
  logic [2:0]  start_pick;
  logic [2:0]  next_pick;
  logic [7:0]  rdata_reg;
  logic        shutdown_request;
  logic        local_channel_en;
  logic        remote1_channel_en;
  logic        remote2_channel_en;
  logic        series_res_correct_en;
  logic        oneshot_wr;

  // first enabled channel at or after the given slot
  function automatic logic [2:0] pick_channel(input logic [2:0] en, input logic [1:0] from);
    logic [2:0] pick;
    pick = 3'h0;
    for (int i = 2; i >= 0; i--) begin
      if (en[i] && (from <= 2'(i))) begin
        pick = {1'b1, 2'(i)};
      end
    end
    return pick;
  endfunction

  // writable configuration registers
  ttc_cfg_reg #(
    .ADDR        (ttc_pkg::ADDR_RUN_RANGE),
    .RESET_VALUE (ttc_pkg::RST_RUN_RANGE),
    .WRITE_MASK  (ttc_pkg::MASK_RUN_RANGE)
  ) u_run_range (
    .clk_in    (clk_in),
    .srst_in   (srst_in),
    .wr_in     (reg_wr_in),
    .addr_in   (reg_addr_in),
    .wdata_in  (reg_wdata_in),
    .value_out (run_range_cfg)
  );

  ttc_cfg_reg #(
    .ADDR        (ttc_pkg::ADDR_CHAN_EN),
    .RESET_VALUE (CHAN_RST),
    .WRITE_MASK  (CHAN_MASK)
  ) u_chan_en (
    .clk_in    (clk_in),
    .srst_in   (srst_in),
    .wr_in     (reg_wr_in),
    .addr_in   (reg_addr_in),
    .wdata_in  (reg_wdata_in),
    .value_out (channel_enable_cfg)
  );

  ttc_cfg_reg #(
    .ADDR        (ttc_pkg::ADDR_RATE),
    .RESET_VALUE (ttc_pkg::RST_RATE),
    .WRITE_MASK  (ttc_pkg::MASK_RATE)
  ) u_rate (
    .clk_in    (clk_in),
    .srst_in   (srst_in),
    .wr_in     (reg_wr_in),
    .addr_in   (reg_addr_in),
    .wdata_in  (reg_wdata_in),
    .value_out (sequence_rate)
  );

  // decoded control fields
  assign shutdown_request      = run_range_cfg[ttc_pkg::BIT_SHUTDOWN];
  assign local_channel_en      = channel_enable_cfg[ttc_pkg::BIT_LOCAL_EN];
  assign remote1_channel_en    = channel_enable_cfg[ttc_pkg::BIT_REMOTE1_EN];
  assign remote2_channel_en    = channel_enable_cfg[ttc_pkg::BIT_REMOTE2_EN];
  assign series_res_correct_en = channel_enable_cfg[ttc_pkg::BIT_RES_CORR];
  assign chan_en               = {remote2_channel_en, remote1_channel_en, local_channel_en};
  assign oneshot_wr            = reg_wr_in && (reg_addr_in == ttc_pkg::ADDR_ONE_SHOT);
  assign start_pick            = pick_channel(chan_en, ttc_pkg::CH_LOCAL);
  assign next_pick             = pick_channel(chan_en, ch_reg + 2'h1);

  // conversion time per channel, halved on remotes without correction
  always_comb begin
    conv_value = 32'(CONV_CYC - 1); // timer also spends a cycle at zero
    if ((ch_next != ttc_pkg::CH_LOCAL) && !series_res_correct_en) begin
      conv_value = 32'((CONV_CYC / 2) - 1);
    end
  end

  // sequence period from the rate code, one less for the cycle spent at zero
  assign period_value = (32'(SEQ_FAST_CYC) << (ttc_pkg::RATE_MAX - sequence_rate[2:0]))
                        - 32'h0000_0001;

  // conversion timer doubles as power-up delay
  ttc_cycle_timer #(
    .W           (32),
    .RESET_COUNT (32'(FIRST_CYC))
  ) u_conv_timer (
    .clk_in        (clk_in),
    .srst_in       (srst_in),
    .load_in       (conv_load),
    .load_value_in (conv_value),
    .expired_out   (conv_expired)
  );

  // period timer runs from each sequence start
  ttc_cycle_timer #(
    .W           (32),
    .RESET_COUNT (32'h0000_0000)
  ) u_period_timer (
    .clk_in        (clk_in),
    .srst_in       (srst_in),
    .load_in       (period_load),
    .load_value_in (period_value),
    .expired_out   (period_expired)
  );

  // sequencer next state
  always_comb begin
    state_next   = state_reg;
    ch_next      = ch_reg;
    oneshot_next = oneshot_reg;
    conv_load    = 1'b0;
    period_load  = 1'b0;
    upd_next     = 1'b0;
    start_seq    = 1'b0;
    case (state_reg)
      ttc_pkg::ST_POWERUP: begin
        if (conv_expired) begin
          if (shutdown_request) begin
            state_next = ttc_pkg::ST_SHUTDOWN;
          end else begin
            start_seq = 1'b1;
          end
        end
      end
      ttc_pkg::ST_CONVERT: begin
        if (conv_expired) begin
          upd_next = 1'b1;
          if (next_pick[2]) begin
            ch_next   = next_pick[1:0];
            conv_load = 1'b1;
          end else if (shutdown_request || oneshot_reg) begin
            state_next   = ttc_pkg::ST_SHUTDOWN;
            oneshot_next = 1'b0;
          end else begin
            state_next = ttc_pkg::ST_IDLE;
          end
        end
      end
      ttc_pkg::ST_IDLE: begin
        if (shutdown_request) begin
          state_next = ttc_pkg::ST_SHUTDOWN;
        end else if (oneshot_wr || period_expired) begin
          start_seq = 1'b1;
        end
      end
      ttc_pkg::ST_SHUTDOWN: begin
        if (!shutdown_request) begin
          start_seq = 1'b1;
        end else if (oneshot_wr) begin
          start_seq    = 1'b1;
          oneshot_next = 1'b1;
        end
      end
      default: begin
        state_next = ttc_pkg::ST_POWERUP;
      end
    endcase
    if (start_seq) begin
      period_load = 1'b1;
      if (start_pick[2]) begin
        state_next = ttc_pkg::ST_CONVERT;
        ch_next    = start_pick[1:0];
        conv_load  = 1'b1;
      end else begin
        state_next   = oneshot_next ? ttc_pkg::ST_SHUTDOWN : ttc_pkg::ST_IDLE;
        oneshot_next = 1'b0;
      end
    end
  end

  // sequencer state
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state_reg   <= ttc_pkg::ST_POWERUP;
      ch_reg      <= ttc_pkg::CH_LOCAL;
      oneshot_reg <= 1'b0;
    end else begin
      state_reg   <= state_next;
      ch_reg      <= ch_next;
      oneshot_reg <= oneshot_next;
    end
  end

  // converter outputs
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= (state_next == ttc_pkg::ST_CONVERT);
    end
  end

  // result update strobe
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      upd_reg    <= 1'b0;
      upd_ch_reg <= ttc_pkg::CH_LOCAL;
    end else begin
      upd_reg <= upd_next;
      if (upd_next) begin
        upd_ch_reg <= ch_reg;
      end
    end
  end

  // register read data
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        ttc_pkg::ADDR_STATUS:    rdata_reg <= {busy_reg, 7'h00};
        ttc_pkg::ADDR_RUN_RANGE: rdata_reg <= run_range_cfg;
        ttc_pkg::ADDR_CHAN_EN:   rdata_reg <= channel_enable_cfg;
        ttc_pkg::ADDR_RATE:      rdata_reg <= sequence_rate;
        default:                 rdata_reg <= 8'h00;
      endcase
    end
  end

  // outputs
  assign reg_rdata_out             = rdata_reg;
  assign conv_active_out           = busy_reg;
  assign conv_channel_out          = ch_reg;
  assign series_res_correct_en_out = series_res_correct_en;
  assign range_extended_out        = run_range_cfg[ttc_pkg::BIT_RANGE];
  assign result_update_out         = upd_reg;
  assign result_channel_out        = upd_ch_reg;

  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  logic [15:0] since_rst_reg;
  logic        touched_reg;

  // helper: cycles since reset and any host write
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      since_rst_reg <= 16'h0000;
      touched_reg   <= 1'b0;
    end else begin
      if (since_rst_reg != 16'hFFFF) begin
        since_rst_reg <= since_rst_reg + 16'h0001;
      end
      if (reg_wr_in) begin
        touched_reg <= 1'b1;
      end
    end
  end

  sequence s_oneshot_in_shutdown;
    (state_reg == ttc_pkg::ST_SHUTDOWN) && shutdown_request && oneshot_wr && (chan_en != 3'h0);
  endsequence

  sequence s_oneshot_done;
    (state_reg == ttc_pkg::ST_CONVERT) && conv_expired && !next_pick[2];
  endsequence

  a_status_read: assert property (
    (reg_rd_in && reg_addr_in == ttc_pkg::ADDR_STATUS) |=> (reg_rdata_out == {$past(busy_reg), 7'h00}))
    else $error("status read does not show conversion flag");

  a_status_ro: assert property (
    (reg_wr_in && reg_addr_in == ttc_pkg::ADDR_STATUS) |=> $stable(run_range_cfg) && $stable(sequence_rate))
    else $error("write to status disturbed a register");

  a_first_start: assert property (
    (since_rst_reg == 16'(FIRST_CYC + 2) && !touched_reg) |-> conv_active_out)
    else $error("first conversion did not begin after power-up");

  a_cfg_write: assert property (
    (reg_wr_in && reg_addr_in == ttc_pkg::ADDR_RUN_RANGE)
      |=> (run_range_cfg == ($past(reg_wdata_in) & ttc_pkg::MASK_RUN_RANGE)))
    else $error("run/range write not stored");

  a_oneshot_start: assert property (
    s_oneshot_in_shutdown |=> (state_reg == ttc_pkg::ST_CONVERT) && oneshot_reg && conv_active_out)
    else $error("one-shot in shutdown did not start a conversion");

  a_oneshot_return: assert property (
    (oneshot_reg ##0 s_oneshot_done) |=> (state_reg == ttc_pkg::ST_SHUTDOWN) && !conv_active_out)
    else $error("one-shot did not return to shutdown");

  a_oneshot_ignored: assert property (
    ((state_reg == ttc_pkg::ST_CONVERT) && !conv_expired && oneshot_wr) |=> $stable(oneshot_reg))
    else $error("one-shot during conversion was not ignored");

  a_resume_run: assert property (
    ((state_reg == ttc_pkg::ST_SHUTDOWN) && !shutdown_request)
      |=> (state_reg == ttc_pkg::ST_CONVERT) || (state_reg == ttc_pkg::ST_IDLE))
    else $error("clearing shutdown did not resume");

  a_skip_disabled: assert property (
    conv_load |-> (ch_next != 2'h3) && chan_en[ch_next])
    else $error("a disabled channel was measured");

  a_idle_oneshot: assert property (
    ((state_reg == ttc_pkg::ST_IDLE) && !shutdown_request && oneshot_wr && start_pick[2])
      |=> (state_reg == ttc_pkg::ST_CONVERT) && (ch_reg == $past(start_pick[1:0])) && conv_active_out)
    else $error("one-shot in idle did not start immediately");

  a_none_enabled: assert property (
    ((state_reg == ttc_pkg::ST_IDLE) && (chan_en == 3'h0) && !reg_wr_in) |=> !conv_active_out [*2])
    else $error("conversion ran with all channels off");

endmodule

// ===== src/ttc_cycle_timer.sv
`timescale 1ns/1ps
module ttc_cycle_timer #(
  parameter int              W           = 32,
  parameter logic [W-1:0]    RESET_COUNT = '0
) (
  // clock and reset
  input  wire logic         clk_in,
  input  wire logic         srst_in,
  // load and status
  input  wire logic         load_in,
  input  wire logic [W-1:0] load_value_in,
  output logic              expired_out
);

  logic [W-1:0] count_reg;

  // down counter, stops at zero
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      count_reg <= RESET_COUNT;
    end else if (load_in) begin
      count_reg <= load_value_in;
    end else if (count_reg != '0) begin
      count_reg <= count_reg - 1'b1;
    end
  end

  assign expired_out = (count_reg == '0);

endmodule

// ===== tb/temp_conversion_control_bench.sv
`timescale 1ns/1ps
module temp_conversion_control_bench;
  localparam int FIRST = 20;
  localparam int CONV  = 40;
  localparam int SEQF  = 200;

  logic       clk;
  logic       srst;
  logic [7:0] addr, wdata, rdata, addr2, wdata2, rdata2;
  logic       wr, rd, busy, corr, rng, upd, wr2, rd2, upd2, saw2;
  logic [1:0] cch, uch, uch2;
  logic [1:0] ch_q[$];
  int         t_q[$];
  int         cyc, busy_n, bad_count, n_tests, rel;
  logic [7:0] v;

  // single remote variant under test
  ttc_conversion_ctrl #(.DUAL_REMOTE(1'b0), .FIRST_CYC(FIRST), .CONV_CYC(CONV),
    .SEQ_FAST_CYC(SEQF)) DUT (
    .clk_in                   (clk),
    .srst_in                  (srst),
    .reg_addr_in              (addr),
    .reg_wr_in                (wr),
    .reg_wdata_in             (wdata),
    .reg_rd_in                (rd),
    .reg_rdata_out            (rdata),
    .conv_active_out          (busy),
    .conv_channel_out         (cch),
    .series_res_correct_en_out(corr),
    .range_extended_out       (rng),
    .result_update_out        (upd),
    .result_channel_out       (uch)
  );
  ttc_host_model host (.clk_in(clk), .reg_addr_out(addr), .reg_wr_out(wr),
    .reg_wdata_out(wdata), .reg_rd_out(rd), .reg_rdata_in(rdata));

  // dual remote variant
  ttc_conversion_ctrl #(.DUAL_REMOTE(1'b1), .FIRST_CYC(FIRST), .CONV_CYC(CONV),
    .SEQ_FAST_CYC(SEQF)) DUT_DUAL (
    .clk_in                   (clk),
    .srst_in                  (srst),
    .reg_addr_in              (addr2),
    .reg_wr_in                (wr2),
    .reg_wdata_in             (wdata2),
    .reg_rd_in                (rd2),
    .reg_rdata_out            (rdata2),
    .conv_active_out          (),
    .conv_channel_out         (),
    .series_res_correct_en_out(),
    .range_extended_out       (),
    .result_update_out        (upd2),
    .result_channel_out       (uch2)
  );
  ttc_host_model host2 (.clk_in(clk), .reg_addr_out(addr2), .reg_wr_out(wr2),
    .reg_wdata_out(wdata2), .reg_rd_out(rd2), .reg_rdata_in(rdata2));

  // clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // result and busy monitor
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (busy === 1'b1) busy_n <= busy_n + 1;
    if (upd === 1'b1) begin
      ch_q.push_back(uch);
      t_q.push_back(cyc);
    end
    if (upd2 === 1'b1 && uch2 === ttc_pkg::CH_REMOTE2) saw2 <= 1'b1;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    if (bad_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // wait a bounded number of cycles for the busy level
  task automatic wait_busy(input logic lvl, input int lim);
    int n;
    n = 0;
    while (busy !== lvl && n < lim) begin
      @(posedge clk);
      #1 n++;
    end
    check({15'h0000, busy}, {15'h0000, lvl});
  endtask

  task automatic window(input int n);
    ch_q.delete();
    t_q.delete();
    busy_n = 0;
    repeat (n) @(posedge clk);
    #1;
  endtask

  // one full sequence: first channel, next channel, spacing and period
  task automatic seq_chk(input logic [1:0] c0, c1, input int gap, per);
    int i;
    i = 0;
    while (i + 2 < ch_q.size() && ch_q[i] !== c0) i++;
    if (i + 2 >= ch_q.size()) begin
      bad_count++;
      $display("[ERR] %0t too few results", $time);
    end else begin
      check({14'h0000, ch_q[i+1]}, {14'h0000, c1});
      check(16'(t_q[i+1] - t_q[i]), 16'(gap));
      if (c1 !== c0) check(16'(t_q[i+2] - t_q[i]), 16'(per));
    end
  endtask

  // reconfigure, let one sequence boundary pass, then observe
  task automatic cfg_run(input logic [7:0] a, d, input int pre, win);
    host.wr(a, d);
    repeat (pre) @(posedge clk);
    window(win);
  endtask

  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    $display("[ERR] %0t watchdog expired", $time);
    close_out();
  end

  // main sequence
  initial begin
    srst = 1'b1;
    cyc = 0;
    busy_n = 0;
    saw2 = 1'b0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rel = cyc;
    host.rd(ttc_pkg::ADDR_STATUS, v);
    check(v, 16'h0000);
    host.rd(ttc_pkg::ADDR_RUN_RANGE, v);
    check(v, 16'h0000);
    host.rd(ttc_pkg::ADDR_CHAN_EN, v);
    check(v, 16'h001C);
    host2.rd(ttc_pkg::ADDR_CHAN_EN, v);
    check(v, 16'h003C);
    host.rd(8'h30, v);
    check(v, 16'h0000);
    host.rd(ttc_pkg::ADDR_RATE, v);
    check(v, 16'h0007);
    // power-up start, local first, status shows activity
    wait_busy(1'b1, 40);
    check(16'(cyc - rel >= FIRST && cyc - rel <= FIRST + 3), 16'h0001);
    check({14'h0000, cch}, {14'h0000, ttc_pkg::CH_LOCAL});
    host.rd(ttc_pkg::ADDR_STATUS, v);
    check(v, 16'h0080);
    host.wr(ttc_pkg::ADDR_STATUS, 8'hFF);
    host.rd(ttc_pkg::ADDR_STATUS, v);
    check(v, 16'h0080);
    // continuous sequences at the reset rate, then one step slower
    window(450);
    seq_chk(ttc_pkg::CH_LOCAL, ttc_pkg::CH_REMOTE1, CONV, SEQF);
    cfg_run(ttc_pkg::ADDR_RATE, 8'h06, 200, 850);
    seq_chk(ttc_pkg::CH_LOCAL, ttc_pkg::CH_REMOTE1, CONV, 2 * SEQF);
    host.rd(ttc_pkg::ADDR_RATE, v);
    check(v, 16'h0006);
    // range select
    host.wr(ttc_pkg::ADDR_RUN_RANGE, 8'h04);
    repeat (2) @(posedge clk);
    check({15'h0000, rng}, 16'h0001);
    host.rd(ttc_pkg::ADDR_RUN_RANGE, v);
    check(v, 16'h0004);
    // correction off halves the remote conversion
    host.wr(ttc_pkg::ADDR_RATE, 8'h07);
    cfg_run(ttc_pkg::ADDR_CHAN_EN, 8'h18, 400, 450);
    check({15'h0000, corr}, 16'h0000);
    seq_chk(ttc_pkg::CH_LOCAL, ttc_pkg::CH_REMOTE1, CONV / 2, SEQF);
    host.rd(ttc_pkg::ADDR_CHAN_EN, v);
    check(v, 16'h0018);
    // skipping of disabled channels
    cfg_run(ttc_pkg::ADDR_CHAN_EN, 8'h14, 200, 650);
    seq_chk(ttc_pkg::CH_REMOTE1, ttc_pkg::CH_REMOTE1, SEQF, SEQF);
    cfg_run(ttc_pkg::ADDR_CHAN_EN, 8'h0C, 200, 650);
    seq_chk(ttc_pkg::CH_LOCAL, ttc_pkg::CH_LOCAL, SEQF, SEQF);
    cfg_run(ttc_pkg::ADDR_CHAN_EN, 8'h00, 200, 600);
    check(16'(busy_n), 16'h0000);
    check(16'(ch_q.size()), 16'h0000);
    // shutdown finishes the running sequence
    host.wr(ttc_pkg::ADDR_CHAN_EN, 8'h1C);
    wait_busy(1'b1, 220);
    repeat (5) @(posedge clk);
    window(0);
    host.wr(ttc_pkg::ADDR_RUN_RANGE, 8'h40);
    repeat (500) @(posedge clk);
    #1;
    check(16'(ch_q.size()), 16'h0002);
    check({15'h0000, busy}, 16'h0000);
    // one-shot in shutdown, a second one while converting is dropped
    window(0);
    host.wr(ttc_pkg::ADDR_ONE_SHOT, 8'hA5);
    wait_busy(1'b1, 4);
    repeat (10) @(posedge clk);
    host.wr(ttc_pkg::ADDR_ONE_SHOT, 8'h5A);
    repeat (400) @(posedge clk);
    #1;
    check(16'(ch_q.size()), 16'h0002);
    check({15'h0000, busy}, 16'h0000);
    // resume, then a one-shot in a long idle gap starts at once
    host.wr(ttc_pkg::ADDR_RUN_RANGE, 8'h00);
    wait_busy(1'b1, 220);
    host.wr(ttc_pkg::ADDR_RATE, 8'h00);
    wait_busy(1'b0, 100);
    repeat (20) @(posedge clk);
    host.wr(ttc_pkg::ADDR_ONE_SHOT, 8'h00);
    wait_busy(1'b1, 4);
    check({15'h0000, saw2}, 16'h0001);
    close_out();
  end
endmodule

// ===== tb/ttc_host_model.sv
`timescale 1ns/1ps
module ttc_host_model (
  // clock
  input  wire logic       clk_in,
  // register port
  output logic [7:0]      reg_addr_out,
  output logic            reg_wr_out,
  output logic [7:0]      reg_wdata_out,
  output logic            reg_rd_out,
  input  wire logic [7:0] reg_rdata_in
);
  // bus idles with both strobes low
  initial begin
    reg_addr_out  = 8'h00;
    reg_wr_out    = 1'b0;
    reg_wdata_out = 8'h00;
    reg_rd_out    = 1'b0;
  end

  // one write strobe; released lines are scrambled so stale data is never trusted
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_addr_out  <= a;
    reg_wdata_out <= (a == ttc_pkg::ADDR_RUN_RANGE) ? (d & ttc_pkg::MASK_RUN_RANGE) : d;
    reg_wr_out    <= 1'b1;
    @(posedge clk_in);
    reg_wr_out    <= 1'b0;
    reg_addr_out  <= ~a;
    reg_wdata_out <= ~d;
  endtask

  // one read strobe; data is taken once the registered answer has settled
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    reg_addr_out <= a;
    reg_rd_out   <= 1'b1;
    @(posedge clk_in);
    reg_rd_out   <= 1'b0;
    reg_addr_out <= ~a;
    @(posedge clk_in);
    #1 d = reg_rdata_in;
  endtask
endmodule
